//--- core/ldr_top.sv
/*
  auxiliary regulator register bank: mode, sequencing and configuration
  registers at their byte offsets, plus the channel controls they steer.
  assumes the serial interface presents one-cycle read and write strobes on
  clk_in, and the sequencer and fault logic share clk_in.
*/
`timescale 1ns/1ps

// ****************************************************************
// top
// ****************************************************************
module ldr_top (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic [5:0] code_select_pin_in,
  input  wire logic       low_power_state_in,
  input  wire logic       hibernate_state_in,
  input  wire logic       high_performance_state_in,
  input  wire logic [7:0] ldo1_active_setting_in,
  input  wire logic [7:0] ldo2_highperf_setting_in,
  input  wire logic       ldo1_step_turn_on_in,
  input  wire logic       ldo1_soft_start_done_flag_in,
  input  wire logic       ldo1_power_good_flag_in,
  input  wire logic       ldo1_fault_flag_in,
  output logic            ldo1_enable_out,
  output logic      [5:0] ldo1_code_out,
  output logic            ldo1_drain_out,
  output logic            ldo2_enable_out,
  output logic      [5:0] ldo2_code_out,
  output logic            ldo2_drain_out,
  output logic      [1:0] ldo1_soft_start_rate_out,
  output logic      [1:0] ldo1_startup_step_out,
  output logic      [2:0] ldo1_delay_out,
  output logic      [1:0] ldo1_scaling_rate_out,
  output logic            ldo1_step_participation_out,
  output logic            ldo1_step_ready_out,
  output logic            interrupt_out_n
);

  localparam int N = ldr_pkg::NUM_MODE_REGS;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [5:0] code_meta;
  logic [5:0] code_sync;
  logic [2:0] state_meta;
  logic [2:0] state_sync;

  // no reset here so the pin value is already settled when reset releases
  always_ff @(posedge clk_in) begin
    code_meta  <= code_select_pin_in;
    code_sync  <= code_meta;
    state_meta <= {high_performance_state_in, hibernate_state_in, low_power_state_in};
    state_sync <= state_meta;
  end

  // ****************************************************************
  // default load after reset
  // ****************************************************************
  logic def_pend;

  // one pulse on the first edge after release; strap caught by clocked logic
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      def_pend <= 1'b1;
    end else begin
      def_pend <= 1'b0;
    end
  end

  // ****************************************************************
  // mode registers
  // ****************************************************************
  logic [7:0] mode_val [N];
  logic [N-1:0] mode_hit;
  logic [7:0] mode_rd  [N];

  generate
    for (genvar i = 0; i < N; i++) begin : g_mode
      assign mode_hit[i] = (reg_addr_in == ldr_pkg::MODE_OFS[i]);
      assign mode_rd[i]  = mode_hit[i] ? mode_val[i] : 8'h00;
      ldr_mode_reg #(
        .RST_VAL (ldr_pkg::MODE_RST[i]),
        .PIN_DEF (ldr_pkg::MODE_PIN_DEF[i])
      ) u_reg (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .wr_in       (reg_wr_in & mode_hit[i]),
        .wdata_in    (reg_wdata_in),
        .def_ld_in   (def_pend),
        .def_code_in (code_sync),
        .value_out   (mode_val[i])
      );
    end
  endgenerate

  // ****************************************************************
  // sequencing and configuration registers
  // ****************************************************************
  logic [7:0] seq_reg;
  logic [7:0] cfg_reg;
  logic       seq_hit;
  logic       cfg_hit;
  logic [7:0] cfg_rd;

  assign seq_hit = (reg_addr_in == ldr_pkg::OFS_LDO1_SEQUENCING);
  assign cfg_hit = (reg_addr_in == ldr_pkg::OFS_LDO1_CONFIG);
  // reserved bits are not stored: bit 6 reads zero, bit 4 reads one
  assign cfg_rd  = cfg_reg | ldr_pkg::CFG_RSV_ONES;                                 // RQ6

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      seq_reg <= ldr_pkg::RST_LDO1_SEQUENCING;
      cfg_reg <= ldr_pkg::RST_LDO1_CONFIGURATION;
    end else begin
      if (reg_wr_in && seq_hit) begin
        seq_reg <= reg_wdata_in;
      end
      if (reg_wr_in && cfg_hit) begin
        cfg_reg <= reg_wdata_in & ldr_pkg::CFG_WR_MASK;                             // RQ5
      end
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [7:0] next_rdata;

  // one-hot hits allow an or of gated terms; unmapped reads give zero
  always_comb begin
    next_rdata = ldr_pkg::RD_UNMAPPED;
    for (int i = 0; i < N; i++) begin
      next_rdata = next_rdata | mode_rd[i];
    end
    if (seq_hit) begin
      next_rdata = seq_reg;
    end
    if (cfg_hit) begin
      next_rdata = cfg_rd;
    end
  end

  // read data holds until the next read strobe
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= next_rdata;
    end
  end

  // ****************************************************************
  // sequencer hand-off
  // ****************************************************************
  logic participate;
  logic ldo1_started;
  logic next_ready;
  logic next_irq_n;

  assign participate = seq_reg[ldr_pkg::SEQ_PART_BIT];
  // a non-participant counts as ready so it never stalls the sequence
  assign next_ready  = ~participate |
                       (ldo1_soft_start_done_flag_in & ldo1_power_good_flag_in);     // RQ10
  assign next_irq_n  = ~(ldo1_fault_flag_in & ~cfg_reg[ldr_pkg::CFG_MASK_BIT]);      // RQ12

  // started only by a step pulse while participating; held until reset
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ldo1_started        <= 1'b0;
      ldo1_step_ready_out <= 1'b1;
      interrupt_out_n     <= 1'b1;
    end else begin
      if (ldo1_step_turn_on_in && participate) begin
        ldo1_started <= 1'b1;                                                       // RQ9
      end
      ldo1_step_ready_out <= next_ready;
      interrupt_out_n     <= next_irq_n;
    end
  end

  // fields go straight out of their register flops
  assign ldo1_soft_start_rate_out = seq_reg[ldr_pkg::SEQ_SSR_MSB:ldr_pkg::SEQ_SSR_LSB];   // RQ7
  assign ldo1_startup_step_out    = seq_reg[ldr_pkg::SEQ_STEP_MSB:ldr_pkg::SEQ_STEP_LSB]; // RQ8
  assign ldo1_delay_out           = seq_reg[ldr_pkg::SEQ_DLY_MSB:0];                      // RQ11
  assign ldo1_scaling_rate_out    = cfg_reg[ldr_pkg::CFG_DVSR_MSB:ldr_pkg::CFG_DVSR_LSB]; // RQ14
  assign ldo1_step_participation_out = participate;

  // ****************************************************************
  // channel controllers
  // ****************************************************************
  ldr_mode_if ldo1_if ();
  ldr_mode_if ldo2_if ();

  assign ldo1_if.act_set   = ldo1_active_setting_in;
  assign ldo1_if.lp_set    = mode_val[0];
  assign ldo1_if.hib_set   = mode_val[1];
  assign ldo1_if.hp_set    = mode_val[2];
  assign ldo1_if.lp_state  = state_sync[0];
  assign ldo1_if.hib_state = state_sync[1];
  assign ldo1_if.hp_state  = state_sync[2];

  assign ldo2_if.act_set   = mode_val[3];
  assign ldo2_if.lp_set    = mode_val[4];
  assign ldo2_if.hib_set   = mode_val[5];
  assign ldo2_if.hp_set    = ldo2_highperf_setting_in;
  assign ldo2_if.lp_state  = state_sync[0];
  assign ldo2_if.hib_state = state_sync[1];
  assign ldo2_if.hp_state  = state_sync[2];

  ldr_chan_ctrl u_ldo1 (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .mode_if      (ldo1_if),
    .sw_sel_in    (cfg_reg[ldr_pkg::CFG_SWSEL_BIT]),
    .sw_on_in     (cfg_reg[ldr_pkg::CFG_SWON_BIT]),
    .started_in   (ldo1_started),
    .drain_sel_in (cfg_reg[ldr_pkg::CFG_DRAIN_BIT]),
    .enable_out   (ldo1_enable_out),
    .code_out     (ldo1_code_out),
    .drain_out    (ldo1_drain_out)
  );

  // second regulator has no override or drain control in this bank
  ldr_chan_ctrl u_ldo2 (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .mode_if      (ldo2_if),
    .sw_sel_in    (1'b0),
    .sw_on_in     (1'b0),
    .started_in   (1'b1),
    .drain_sel_in (1'b0),
    .enable_out   (ldo2_enable_out),
    .code_out     (ldo2_code_out),
    .drain_out    (ldo2_drain_out)
  );

endmodule : ldr_top

//--- core/ldr_pkg.sv
/*
  constants for the auxiliary regulator mode and configuration register bank:
  register offsets, field positions, reset values and reserved-bit read values.
  assumes an 8-bit register space reached through a byte-wide access port.
*/
// Function
// (RQ1) top enable bit of a mode register keeps the regulator on in that mode.
// (RQ2) low six bits select the output voltage code used in the matching mode.
// (RQ3) first regulator mode codes default to the external selection pin value.
// (RQ4) second regulator active, low-power, hibernate codes default to 3.3V code.
// (RQ5) software keeps bit 6 of mode and configuration registers at zero.
// (RQ6) software keeps configuration bit 4 of the first regulator at one.
// (RQ7) sequencing bits 7-6 select the soft start ramp rate.
// (RQ8) sequencing bits 5-4 assign the power-up sequence step.
// (RQ9) cleared participation bit stops turn-on at the assigned step.
// (RQ10) cleared participation bit makes the sequencer ignore done and good flags.
// (RQ11) sequencing bits 2-0 set the delay before soft start begins.
// (RQ12) set fault mask bit keeps a fault from pulling the interrupt low.
// (RQ13) discharge bit drains the output while the regulator is off.
// (RQ14) configuration bits 3-2 program the voltage scaling slew rate.
// (RQ15) with software select zero the software on bit is ignored.
// (RQ16) with software select one the software on bit forces channel on or off.
// (RQ17) each mode change applies enable and code of the newly entered mode.

// ****************************************************************
// package
// ****************************************************************
package ldr_pkg;

  localparam int NUM_MODE_REGS = 6;

  // register offsets
  localparam logic [7:0] OFS_LDO1_LOWPOWER  = 8'h51;
  localparam logic [7:0] OFS_LDO1_HIBERNATE = 8'h52;
  localparam logic [7:0] OFS_LDO1_HIGHPERF  = 8'h53;
  localparam logic [7:0] OFS_LDO1_SEQUENCING = 8'h54;
  localparam logic [7:0] OFS_LDO1_CONFIG    = 8'h55;
  localparam logic [7:0] OFS_LDO2_ACTIVE    = 8'h60;
  localparam logic [7:0] OFS_LDO2_LOWPOWER  = 8'h61;
  localparam logic [7:0] OFS_LDO2_HIBERNATE = 8'h62;

  // mode register fields
  localparam int MODE_EN_BIT   = 7;
  localparam int MODE_RSV_BIT  = 6;
  localparam int CODE_MSB      = 5;

  // sequencing fields
  localparam int SEQ_SSR_MSB   = 7;
  localparam int SEQ_SSR_LSB   = 6;
  localparam int SEQ_STEP_MSB  = 5;
  localparam int SEQ_STEP_LSB  = 4;
  localparam int SEQ_PART_BIT  = 3;
  localparam int SEQ_DLY_MSB   = 2;

  // configuration fields
  localparam int CFG_MASK_BIT  = 7;
  localparam int CFG_RSV0_BIT  = 6;
  localparam int CFG_DRAIN_BIT = 5;
  localparam int CFG_RSV1_BIT  = 4;
  localparam int CFG_DVSR_MSB  = 3;
  localparam int CFG_DVSR_LSB  = 2;
  localparam int CFG_SWON_BIT  = 1;
  localparam int CFG_SWSEL_BIT = 0;

  // writable bits; the rest are reserved
  localparam logic [7:0] MODE_WR_MASK = 8'hBF;
  localparam logic [7:0] CFG_WR_MASK  = 8'hAF;
  localparam logic [7:0] CFG_RSV_ONES = 8'h10;

  // reset values
  localparam logic [5:0] CODE_3V3           = 6'h37;
  localparam logic [7:0] RST_LDO1_LOWPOWER  = 8'h80;
  localparam logic [7:0] RST_LDO1_HIBERNATE = 8'h00;
  localparam logic [7:0] RST_LDO1_HIGHPERF  = 8'h80;
  localparam logic [7:0] RST_LDO1_SEQUENCING       = 8'h09;
  localparam logic [7:0] RST_LDO1_CONFIGURATION       = 8'hA0;
  localparam logic [7:0] RST_LDO2_MODE      = {2'h0, CODE_3V3};

  // mode register table, index order: ldo1 lp, hib, hp, ldo2 act, lp, hib
  localparam logic [7:0] MODE_OFS [NUM_MODE_REGS] = '{
    OFS_LDO1_LOWPOWER, OFS_LDO1_HIBERNATE, OFS_LDO1_HIGHPERF,
    OFS_LDO2_ACTIVE, OFS_LDO2_LOWPOWER, OFS_LDO2_HIBERNATE};
  localparam logic [7:0] MODE_RST [NUM_MODE_REGS] = '{
    RST_LDO1_LOWPOWER, RST_LDO1_HIBERNATE, RST_LDO1_HIGHPERF,
    RST_LDO2_MODE, RST_LDO2_MODE, RST_LDO2_MODE};
  localparam logic MODE_PIN_DEF [NUM_MODE_REGS] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

  localparam logic [7:0] RD_UNMAPPED = 8'h00;

endpackage : ldr_pkg

//--- core/ldr_mode_if.sv
/*
  mode settings bundle passed from the register bank to a channel controller.
  assumes all members are on the single core clock.
*/
`timescale 1ns/1ps

// ****************************************************************
// interface
// ****************************************************************
interface ldr_mode_if;
  logic [7:0] act_set;
  logic [7:0] lp_set;
  logic [7:0] hib_set;
  logic [7:0] hp_set;
  logic       lp_state;
  logic       hib_state;
  logic       hp_state;

  modport bank (output act_set, lp_set, hib_set, hp_set, lp_state, hib_state, hp_state);
  modport chan (input  act_set, lp_set, hib_set, hp_set, lp_state, hib_state, hp_state);
endinterface : ldr_mode_if

//--- core/ldr_mode_reg.sv
/*
  one mode register: enable bit and six-bit voltage code, reserved bit 6 reads zero.
  assumes def_ld_in pulses once after reset release with a settled pin code.
*/
`timescale 1ns/1ps

// ****************************************************************
// mode register
// ****************************************************************
module ldr_mode_reg #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic       PIN_DEF = 1'b0
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       def_ld_in,
  input  wire logic [5:0] def_code_in,
  output logic      [7:0] value_out
);

  logic [7:0] next_value;

  // write beats the one-shot default load; reserved bit is never stored
  assign next_value = wr_in ? (wdata_in & ldr_pkg::MODE_WR_MASK)                 // RQ5
                    : (def_ld_in && PIN_DEF) ? {value_out[7:6], def_code_in}      // RQ3
                    : value_out;

  // reset value is a constant; pin default arrives one edge after release
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      value_out <= RST_VAL;                                                       // RQ4
    end else begin
      value_out <= next_value;
    end
  end

endmodule : ldr_mode_reg

//--- core/ldr_chan_ctrl.sv
/*
  channel controller: picks the setting of the current operating mode and
  resolves software override and output drain.
  assumes mode state levels are already synchronised to clk_in.
*/
`timescale 1ns/1ps

// ****************************************************************
// channel controller
// ****************************************************************
module ldr_chan_ctrl (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  ldr_mode_if.chan        mode_if,
  input  wire logic       sw_sel_in,
  input  wire logic       sw_on_in,
  input  wire logic       started_in,
  input  wire logic       drain_sel_in,
  output logic            enable_out,
  output logic      [5:0] code_out,
  output logic            drain_out
);

  logic [7:0] sel_set;
  logic       mode_on;
  logic       next_on;

  // hibernate outranks low power, which outranks high performance
  assign sel_set = mode_if.hib_state ? mode_if.hib_set                             // RQ17
                 : mode_if.lp_state  ? mode_if.lp_set
                 : mode_if.hp_state  ? mode_if.hp_set
                 : mode_if.act_set;
  assign mode_on = sel_set[ldr_pkg::MODE_EN_BIT] & started_in;                     // RQ1
  // override only when software select is set; otherwise sw_on is dont-care
  assign next_on = sw_sel_in ? sw_on_in : mode_on;                                 // RQ15 RQ16

  // outputs registered so the analog side sees glitch-free controls
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      enable_out <= 1'b0;
      code_out   <= 6'h00;
      drain_out  <= 1'b0;
    end else begin
      enable_out <= next_on;
      code_out   <= sel_set[ldr_pkg::CODE_MSB:0];                                  // RQ2
      drain_out  <= drain_sel_in & ~next_on;                                       // RQ13
    end
  end

endmodule : ldr_chan_ctrl

//--- dv/ldr_host_model.sv
/*
  host side model: drives the byte strobe register port of the bank.
  assumes the bank samples strobes, address and data on the rising clk_in edge.
*/
`timescale 1ns/1ps

// ****************************************************************
// host model
// ****************************************************************
module ldr_host_model (
  input  wire logic       clk_in,
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out,
  input  wire logic [7:0] rdata_in
);
  // idle port at time zero
  initial begin
    addr_out  = 8'h00;
    wdata_out = 8'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end

  // one-cycle write; address and data inverted once released so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a inside {8'h51, 8'h52, 8'h53, 8'h55, 8'h60, 8'h61, 8'h62}) v[6] = 1'b0;
    if (a == 8'h55) v[4] = 1'b1;
    @(negedge clk_in);
    addr_out  = a;
    wdata_out = v;
    wr_out    = 1'b1;
    @(negedge clk_in);
    wr_out    = 1'b0;
    addr_out  = ~a;
    wdata_out = ~v;
  endtask : wr

  // one-cycle read; data is taken one and a half cycles after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    rd_out   = 1'b1;
    @(negedge clk_in);
    rd_out   = 1'b0;
    addr_out = ~a;
    @(negedge clk_in);
    d = rdata_in;
  endtask : rd
endmodule : ldr_host_model

//--- dv/ldr_top_asserts.sv
/*
  checker for the regulator register bank, watching its top ports only.
  assumes it is bound to ldr_top and that the core runs on clk_in alone.
*/
`timescale 1ns/1ps

// ****************************************************************
// checker
// ****************************************************************
module ldr_top_asserts (
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       ldo1_soft_start_done_flag_in,
  input wire logic       ldo1_power_good_flag_in,
  input wire logic       ldo1_fault_flag_in,
  input wire logic       ldo1_enable_out,
  input wire logic       ldo1_drain_out,
  input wire logic       ldo2_drain_out,
  input wire logic [1:0] ldo1_soft_start_rate_out,
  input wire logic [1:0] ldo1_startup_step_out,
  input wire logic [2:0] ldo1_delay_out,
  input wire logic [1:0] ldo1_scaling_rate_out,
  input wire logic       ldo1_step_participation_out,
  input wire logic       ldo1_step_ready_out,
  input wire logic       interrupt_out_n
);
  logic [7:0] sh_seq;
  logic [7:0] sh_cfg;
  logic [1:0] up;
  wire logic  c_sel   = sh_cfg[0];
  wire logic  c_on    = sh_cfg[1];
  wire logic  c_drain = sh_cfg[5];
  wire logic  c_mask  = sh_cfg[7];

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // shadow bytes; up gates $past checks until reset values have left the pipeline
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sh_seq <= 8'h09;
      sh_cfg <= 8'hB0;
      up     <= 2'h0;
    end else begin
      if (up != 2'h3) up <= up + 2'h1;
      if (reg_wr_in && reg_addr_in == 8'h54) sh_seq <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == 8'h55) sh_cfg <= (reg_wdata_in & 8'hAF) | 8'h10;
    end
  end

  a_seq_fields: assert property (
    {ldo1_soft_start_rate_out, ldo1_startup_step_out, ldo1_step_participation_out,
     ldo1_delay_out} == sh_seq) else $error("sequencing outputs differ from register");
  a_scale_rate: assert property (
    ldo1_scaling_rate_out == sh_cfg[3:2]) else $error("scaling rate differs");
  a_seq_read: assert property (
    reg_rd_in && reg_addr_in == 8'h54 |=> reg_rdata_out == $past(sh_seq))
    else $error("sequencing readback wrong");
  a_cfg_read: assert property (
    reg_rd_in && reg_addr_in == 8'h55 |=> reg_rdata_out == $past(sh_cfg))
    else $error("configuration readback wrong");
  a_ready_flag: assert property (
    up == 2'h3 |-> ldo1_step_ready_out == (!$past(ldo1_step_participation_out) ||
    ($past(ldo1_soft_start_done_flag_in) && $past(ldo1_power_good_flag_in))))
    else $error("step ready flag wrong");
  a_irq_mask: assert property (
    up == 2'h3 |-> interrupt_out_n == !($past(ldo1_fault_flag_in) && !$past(c_mask)))
    else $error("interrupt level wrong");
  a_sw_force: assert property (
    up == 2'h3 && $past(c_sel) |-> ldo1_enable_out == $past(c_on))
    else $error("software override not applied");
  a_drain_off: assert property (
    up == 2'h3 |-> ldo1_drain_out == ($past(c_drain) && !ldo1_enable_out))
    else $error("discharge level wrong");
  a_ldo2_drain: assert property (
    !ldo2_drain_out) else $error("second regulator discharging");
endmodule : ldr_top_asserts

//--- dv/tb.sv
/*
  self-checking bench for the regulator register bank.
  assumes the host model drives the register port and the bench the pins.
*/
`timescale 1ns/1ps

// ****************************************************************
// bench
// ****************************************************************
module tb;
  logic        clk_in, rst_n_in, reg_wr_in, reg_rd_in;
  logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out, rdv;
  logic [5:0]  code_select_pin_in, ldo1_code_out, ldo2_code_out;
  logic        low_power_state_in, hibernate_state_in, high_performance_state_in;
  logic [7:0]  ldo1_active_setting_in, ldo2_highperf_setting_in;
  logic        ldo1_step_turn_on_in, ldo1_soft_start_done_flag_in;
  logic        ldo1_power_good_flag_in, ldo1_fault_flag_in, interrupt_out_n;
  logic        ldo1_enable_out, ldo1_drain_out, ldo2_enable_out, ldo2_drain_out;
  logic [1:0]  ldo1_soft_start_rate_out, ldo1_startup_step_out, ldo1_scaling_rate_out;
  logic [2:0]  ldo1_delay_out;
  logic        ldo1_step_participation_out, ldo1_step_ready_out;
  int          n_mismatch, checked;
  // reset rows: offset, value; the last offset is unmapped
  logic [15:0] rst_rows [9] = '{16'h51AA, 16'h522A, 16'h53AA, 16'h5409, 16'h55B0,
                                16'h6037, 16'h6137, 16'h6237, 16'h7000};
  // mode rows: {lp, hib, hp}, expected {en1, 0, code1, en2, 0, code2}
  logic [18:0] mode_rows [5] = '{{3'b000, 16'h9537}, {3'b100, 16'h85B3},
    {3'b010, 16'h2A37}, {3'b110, 16'h2A37}, {3'b001, 16'hAA9C}};

  ldr_top DUT (.clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .code_select_pin_in, .low_power_state_in, .hibernate_state_in,
    .high_performance_state_in, .ldo1_active_setting_in, .ldo2_highperf_setting_in,
    .ldo1_step_turn_on_in, .ldo1_soft_start_done_flag_in, .ldo1_power_good_flag_in,
    .ldo1_fault_flag_in, .ldo1_enable_out, .ldo1_code_out, .ldo1_drain_out,
    .ldo2_enable_out, .ldo2_code_out, .ldo2_drain_out, .ldo1_soft_start_rate_out,
    .ldo1_startup_step_out, .ldo1_delay_out, .ldo1_scaling_rate_out,
    .ldo1_step_participation_out, .ldo1_step_ready_out, .interrupt_out_n);
  ldr_host_model u_host (.clk_in(clk_in), .addr_out(reg_addr_in),
    .wdata_out(reg_wdata_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in),
    .rdata_in(reg_rdata_out));

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  // sequencer turn-on pulse, one cycle wide
  task automatic pulse();
    @(negedge clk_in);
    ldo1_step_turn_on_in = 1'b1;
    @(negedge clk_in);
    ldo1_step_turn_on_in = 1'b0;
    repeat (2) @(negedge clk_in);
  endtask : pulse

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // hang guard: the main sequence needs far fewer cycles
  initial begin
    repeat (5000) @(posedge clk_in);
    n_mismatch++;
    finish_test();
  end

  initial begin
    rst_n_in = 1'b0;
    code_select_pin_in = 6'h2A;
    {low_power_state_in, hibernate_state_in, high_performance_state_in} = 3'b000;
    ldo1_active_setting_in = 8'h95;
    ldo2_highperf_setting_in = 8'h9C;
    {ldo1_step_turn_on_in, ldo1_soft_start_done_flag_in} = 2'b00;
    {ldo1_power_good_flag_in, ldo1_fault_flag_in} = 2'b00;
    n_mismatch = 0;
    checked = 0;
    repeat (12) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (2) @(negedge clk_in);
    foreach (rst_rows[i]) begin
      u_host.rd(rst_rows[i][15:8], rdv);
      chk("reset value", rdv, rst_rows[i][7:0]);
    end
    // participation off: sw on bit without select and the turn-on pulse are both ignored
    u_host.wr(8'h54, 8'hF5);
    chk("seq fields", {ldo1_soft_start_rate_out, ldo1_startup_step_out,
      ldo1_step_participation_out, ldo1_delay_out}, 8'hF5);
    u_host.wr(8'h55, 8'h1E);
    chk("scaling rate", ldo1_scaling_rate_out, 2'h3);
    pulse();
    chk("enable before start", ldo1_enable_out, 1'b0);
    chk("ready unjoined", ldo1_step_ready_out, 1'b1);
    u_host.wr(8'h54, 8'h08);
    repeat (2) @(negedge clk_in);
    chk("ready joined", ldo1_step_ready_out, 1'b0);
    {ldo1_soft_start_done_flag_in, ldo1_power_good_flag_in} = 2'b11;
    pulse();
    chk("ready flags met", ldo1_step_ready_out, 1'b1);
    chk("ldo1 started", {ldo1_enable_out, 1'b0, ldo1_code_out}, 8'h95);
    u_host.wr(8'h55, 8'h31);
    repeat (2) @(negedge clk_in);
    chk("forced off", {ldo1_enable_out, ldo1_drain_out}, 2'b01);
    u_host.wr(8'h55, 8'h80);
    u_host.wr(8'h51, 8'hC5);
    u_host.wr(8'h61, 8'hB3);
    u_host.rd(8'h51, rdv);
    chk("lowpower byte", rdv, 8'h85);
    foreach (mode_rows[i]) begin
      {low_power_state_in, hibernate_state_in, high_performance_state_in} = mode_rows[i][18:16];
      repeat (4) @(negedge clk_in);
      chk("mode outputs", {ldo1_enable_out, 1'b0, ldo1_code_out, ldo2_enable_out, 1'b0,
        ldo2_code_out}, mode_rows[i][15:0]);
    end
    // fault is held first under the mask set by the 8'h80 write, then with the mask cleared
    ldo1_fault_flag_in = 1'b1;
    repeat (2) @(negedge clk_in);
    chk("irq masked", interrupt_out_n, 1'b1);
    u_host.wr(8'h55, 8'h00);
    repeat (2) @(negedge clk_in);
    chk("irq unmasked", interrupt_out_n, 1'b0);
    ldo1_fault_flag_in = 1'b0;
    // second reset in mid-run clears the start latch and reloads a new pin code
    code_select_pin_in = 6'h15;
    rst_n_in = 1'b0;
    repeat (3) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (3) @(negedge clk_in);
    chk("start cleared", ldo1_enable_out, 1'b0);
    u_host.rd(8'h55, rdv);
    chk("cfg after reset", rdv, 8'hB0);
    u_host.rd(8'h53, rdv);
    chk("pin default", rdv, 8'h95);
    // override turns the channel on although the sequencer never started it
    u_host.wr(8'h55, 8'h03);
    repeat (2) @(negedge clk_in);
    chk("forced on", ldo1_enable_out, 1'b1);
    finish_test();
  end
endmodule : tb

bind ldr_top ldr_top_asserts u_chk (.clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .ldo1_soft_start_done_flag_in,
  .ldo1_power_good_flag_in, .ldo1_fault_flag_in, .ldo1_enable_out, .ldo1_drain_out,
  .ldo2_drain_out, .ldo1_soft_start_rate_out, .ldo1_startup_step_out, .ldo1_delay_out,
  .ldo1_scaling_rate_out, .ldo1_step_participation_out, .ldo1_step_ready_out,
  .interrupt_out_n);
